// ---- rtl/adc_serial_port.v ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_regs.vh"
// Functional notes
// - mode pin low: external clock input, raw word sent msb first
// - mode pin high: self-clocked, device drives serial clock out
// - self clock is master clock over four, high one quarter
// - calibration select pins sampled when calibration strobe rises
// - strobe held over four cycles resets; falling edge starts calibration
// - sleep pin low puts device in standby, new word loads blocked
// - range select low unipolar, high bipolar
// - chip select falling starts sending in selected mode
// - data-ready low while a valid word is held
// - data-ready returns high when a word transmission finishes
// - every new word load forces data-ready high four cycles
// - each result is sent as twenty serial bits unless deselected early
// - data bits change on serial clock falling edge
// - early deselect: self-clocked finishes current bit then releases data and clock; external clock releases data at once
// - chip select during four-cycle high window is ignored
module adc_serial_port #(
    parameter WORD_W = `WORD_BITS
) (
    // master clock and reset
    input wire core_clk,
    input wire rst_n,
    // configuration pins and calibration strobe
    input wire serial_mode_sel,
    input wire range_select,
    input wire sleep_n,
    input wire cal_type_sel_a,
    input wire cal_type_sel_b,
    input wire cal_strobe,
    // conversion words from the filter
    input wire conv_valid,
    output wire conv_ready,
    input wire [WORD_W-1:0] conv_data,
    // serial link
    input wire cs_n,
    input wire sclk_in,
    output reg sclk_out,
    output reg sclk_oe,
    output reg serial_out_line,
    output reg serial_out_oe,
    output reg word_valid_n,
    // status toward the analog core
    output reg bipolar_reg,
    output reg standby_reg,
    output reg core_reset_reg,
    output reg cal_start_reg,
    output reg [1:0] cal_kind_reg
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SEND = 2'h1;
    localparam ST_DRAIN = 2'h2;

    reg [1:0] state_reg;
    reg [WORD_W-1:0] shift_reg;
    reg [4:0] bits_left_reg;
    reg [1:0] phase_reg;
    reg [2:0] hold_cnt_reg;
    reg [2:0] cal_cnt_reg;
    reg cal_long_reg;
    reg have_word_reg;
    reg [1:0] cs_sync_reg;
    reg [1:0] sclk_sync_reg;
    reg [1:0] mode_sync_reg;
    reg [1:0] range_sync_reg;
    reg [1:0] sleep_sync_reg;
    reg [1:0] cal_sync_reg;
    reg [1:0] sca_sync_reg;
    reg [1:0] scb_sync_reg;
    reg sclk_prev_reg;
    reg cal_prev_reg;
    wire buf_valid;
    wire buf_take;
    wire [WORD_W-1:0] buf_data;
    wire cs_act;
    wire self_clk;
    wire ext_fall;
    wire gen_fall;
    wire bit_fall;
    wire cal_rise;
    wire cal_fall;

    assign cs_act = ~cs_sync_reg[1];
    assign self_clk = mode_sync_reg[1];
    assign ext_fall = sclk_prev_reg && !sclk_sync_reg[1];
    assign gen_fall = (phase_reg == `SCLK_HIGH_PHASE);
    assign bit_fall = self_clk ? gen_fall : ext_fall;
    assign cal_rise = cal_sync_reg[1] && !cal_prev_reg;
    assign cal_fall = !cal_sync_reg[1] && cal_prev_reg;
    // load a new word only once the held one is spent, never while sending,
    // in standby or in calibration reset, so a slow reader loses no word
    assign buf_take = buf_valid && (state_reg == ST_IDLE) && (hold_cnt_reg == 3'h0)
        && standby_reg == 1'b0 && !cal_long_reg && !have_word_reg;

    // buffer holds words so a slow reader loses none
    word_buffer #(
        .WIDTH(WORD_W)
    ) u_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_data),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    // two-flop synchronisers for all pins
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_sync_reg <= 2'h3;
            sclk_sync_reg <= 2'h0;
            mode_sync_reg <= 2'h0;
            range_sync_reg <= 2'h0;
            sleep_sync_reg <= 2'h3;
            cal_sync_reg <= 2'h0;
            sca_sync_reg <= 2'h0;
            scb_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
            cal_prev_reg <= 1'b0;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[0], cs_n};
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
            mode_sync_reg <= {mode_sync_reg[0], serial_mode_sel};
            range_sync_reg <= {range_sync_reg[0], range_select};
            sleep_sync_reg <= {sleep_sync_reg[0], sleep_n};
            cal_sync_reg <= {cal_sync_reg[0], cal_strobe};
            sca_sync_reg <= {sca_sync_reg[0], cal_type_sel_a};
            scb_sync_reg <= {scb_sync_reg[0], cal_type_sel_b};
            sclk_prev_reg <= sclk_sync_reg[1];
            cal_prev_reg <= cal_sync_reg[1];
        end
    end

    // configuration, standby and calibration control
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bipolar_reg <= 1'b0;
            standby_reg <= 1'b0;
            core_reset_reg <= 1'b0;
            cal_start_reg <= 1'b0;
            cal_kind_reg <= `CAL_SELF;
            cal_cnt_reg <= 3'h0;
            cal_long_reg <= 1'b0;
        end
        else
        begin
            bipolar_reg <= range_sync_reg[1];
            standby_reg <= ~sleep_sync_reg[1];
            cal_start_reg <= 1'b0;
            if (cal_rise)
                cal_kind_reg <= {scb_sync_reg[1], sca_sync_reg[1]};
            if (!cal_sync_reg[1])
                cal_cnt_reg <= 3'h0;
            else if (cal_cnt_reg != 3'h7)
                cal_cnt_reg <= cal_cnt_reg + 3'h1;
            if (cal_sync_reg[1] && cal_cnt_reg >= `CAL_MIN_CYCLES)
                cal_long_reg <= 1'b1;
            core_reset_reg <= cal_long_reg && cal_sync_reg[1];
            if (cal_fall)
            begin
                cal_start_reg <= cal_long_reg;
                cal_long_reg <= 1'b0;
            end
        end
    end

    // serial transmit engine
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            shift_reg <= {WORD_W{1'b0}};
            bits_left_reg <= 5'h0;
            phase_reg <= 2'h0;
            hold_cnt_reg <= 3'h0;
            have_word_reg <= 1'b0;
            word_valid_n <= 1'b1;
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            serial_out_line <= 1'b0;
            serial_out_oe <= 1'b0;
        end
        else
        begin
            if (hold_cnt_reg != 3'h0)
                hold_cnt_reg <= hold_cnt_reg - 3'h1;
            if (buf_take)
            begin
                shift_reg <= buf_data;
                have_word_reg <= 1'b1;
                hold_cnt_reg <= `LOAD_HOLD_CYCLES;
            end
            word_valid_n <= !(have_word_reg && hold_cnt_reg == 3'h0 && !buf_take);
            if (cal_long_reg)
            begin
                state_reg <= ST_IDLE;
                have_word_reg <= 1'b0;
                serial_out_oe <= 1'b0;
                sclk_oe <= 1'b0;
                sclk_out <= 1'b0;
            end
            else
            case (state_reg)
            ST_IDLE:
            begin
                serial_out_oe <= 1'b0;
                sclk_oe <= 1'b0;
                sclk_out <= 1'b0;
                phase_reg <= 2'h0;
                // select starts send; ignored in hold window
                if (cs_act && have_word_reg && hold_cnt_reg == 3'h0 && !buf_take)
                begin
                    state_reg <= ST_SEND;
                    serial_out_line <= shift_reg[WORD_W-1];
                    serial_out_oe <= 1'b1;
                    sclk_oe <= self_clk;
                    bits_left_reg <= WORD_W[4:0];
                end
            end
            ST_SEND:
            begin
                phase_reg <= phase_reg + 2'h1;
                sclk_out <= self_clk && (phase_reg == 2'h2);
                if (bit_fall)
                begin
                    shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
                    serial_out_line <= shift_reg[WORD_W-2];
                    bits_left_reg <= bits_left_reg - 5'h1;
                    // early deselect releases after current bit
                    // finished or cut word returns data-ready high
                    if (!cs_act || bits_left_reg == 5'h1)
                    begin
                        state_reg <= ST_DRAIN;
                        have_word_reg <= 1'b0;
                    end
                end
                // an external clock may stop once deselected
                else if (!cs_act && !self_clk)
                begin
                    state_reg <= ST_DRAIN;
                    have_word_reg <= 1'b0;
                end
            end
            ST_DRAIN:
            begin
                serial_out_oe <= 1'b0;
                sclk_oe <= 1'b0;
                sclk_out <= 1'b0;
                if (!cs_act || have_word_reg)
                    state_reg <= ST_IDLE;
            end
            default:
                state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- inc/adc_serial_regs.vh ----
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH
// word layout
`define WORD_BITS 20
`define WORD_MSB 19
// self-clocked serial clock: divide by four, high one phase in four
`define SCLK_DIV 4
`define SCLK_HIGH_PHASE 2'h3
// data-ready forced high after each new word, in master cycles
`define LOAD_HOLD_CYCLES 3'h4
// calibration strobe must be seen high for more than this many cycles
`define CAL_MIN_CYCLES 3'h4
// calibration kinds from the two select pins (b, a)
`define CAL_SELF 2'h3
`endif

// ---- rtl/word_buffer.v ----
`timescale 1ns/100ps
`default_nettype none
// two-entry buffer for conversion words
module word_buffer #(
    parameter WIDTH = 20
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg rd_ptr_reg;
    reg wr_ptr_reg;
    reg [1:0] count_reg;
    reg ready_reg;
    wire do_wr;
    wire do_rd;

    // ready comes from a flop so the fill side sees a clean level
    assign in_ready = ready_reg;
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // pointer and occupancy update
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            ready_reg <= 1'b1;
            mem_reg[0] <= {WIDTH{1'b0}};
            mem_reg[1] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (do_rd)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (do_wr && !do_rd)
            begin
                count_reg <= count_reg + 2'h1;
                ready_reg <= (count_reg == 2'h0);
            end
            else if (do_rd && !do_wr)
            begin
                count_reg <= count_reg - 2'h1;
                ready_reg <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/adc_serial_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// watches the serial port pins and status outputs
module adc_serial_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration pins
    input wire logic serial_mode_sel,
    input wire logic range_select,
    input wire logic sleep_n,
    input wire logic cal_type_sel_a,
    input wire logic cal_type_sel_b,
    input wire logic cal_strobe,
    // serial link
    input wire logic cs_n,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    input wire logic word_valid_n,
    // status
    input wire logic bipolar_reg,
    input wire logic standby_reg,
    input wire logic core_reset_reg,
    input wire logic cal_start_reg,
    input wire logic [1:0] cal_kind_reg
);
    // all checks run on the master clock
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    ext_clock_quiet_a: assert property (!serial_mode_sel [*6] |-> !sclk_oe)
        else $error("serial clock driven in external mode");
    self_clock_on_a: assert property ($rose(serial_out_oe) && serial_mode_sel
        |-> ##[0:4] sclk_oe)
        else $error("serial clock not driven in self mode");
    self_clock_duty_a: assert property ($rose(sclk_out) |=>
        !sclk_out [*3] ##1 (sclk_out || !serial_out_oe))
        else $error("self clock not one high in four");
    cal_kind_take_a: assert property ($rose(cal_strobe) |->
        ##[1:4] cal_kind_reg == {cal_type_sel_b, cal_type_sel_a})
        else $error("calibration kind not taken");
    cal_reset_a: assert property (cal_strobe [*6] |-> ##[0:3] core_reset_reg)
        else $error("long strobe gave no reset");
    cal_start_a: assert property (cal_strobe [*6] ##1 !cal_strobe |->
        ##[0:4] cal_start_reg)
        else $error("strobe fall gave no calibration start");
    sleep_follow_a: assert property ($stable(sleep_n) [*4] |->
        standby_reg == !sleep_n)
        else $error("standby does not follow sleep pin");
    range_follow_a: assert property ($stable(range_select) [*4] |->
        bipolar_reg == range_select)
        else $error("bipolar does not follow range pin");
    load_hold_a: assert property ($fell(word_valid_n) |->
        $past(word_valid_n, 2) && $past(word_valid_n, 3) && $past(word_valid_n, 4))
        else $error("data ready high less than four cycles");
    bit_on_fall_a: assert property ($changed(serial_out_line) && serial_out_oe
        && $past(serial_out_oe) |-> !sclk_out)
        else $error("data changed while serial clock high");
    idle_release_a: assert property (cs_n [*8] |-> !serial_out_oe)
        else $error("data driven while deselected");
endmodule
bind adc_serial_port adc_serial_monitor i_mon (.core_clk, .rst_n, .serial_mode_sel, .range_select,
    .sleep_n, .cal_type_sel_a, .cal_type_sel_b, .cal_strobe, .cs_n, .sclk_out, .sclk_oe,
    .serial_out_line, .serial_out_oe, .word_valid_n, .bipolar_reg, .standby_reg,
    .core_reset_reg, .cal_start_reg, .cal_kind_reg);
`default_nettype wire

// ---- tb/host_reader.sv ----
`timescale 1ns/100ps
`default_nettype none
// host shift register reading words from the serial port
module host_reader (
    // master clock for self-clocked sampling
    input wire logic core_clk,
    // serial link
    output logic cs_n,
    output logic sclk_in,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic serial_out_line,
    input wire logic serial_out_oe
);
    logic drv = 1'b0;
    logic last_bit = 1'b0;
    // set when a generated clock never showed up
    logic timed_out = 1'b0;
    // released data line shows the inverse of its last level
    wire logic sd = serial_out_oe ? serial_out_line : ~last_bit;
    // clock pin level from whichever side drives it
    assign sclk_in = sclk_oe ? sclk_out : drv;
    initial cs_n = 1'b1;
    // remember the last driven data level
    always @(posedge core_clk)
        if (serial_out_oe)
            last_bit <= serial_out_line;
    // select, clock in nbits msb first, deselect
    task automatic read_word(input logic self, input int nbits, output logic [19:0] w);
        int n;
        w = 20'h0;
        cs_n = 1'b0;
        if (!self)
            #480;
        for (int i = 0; i < nbits; i++)
        begin
            n = 0;
            // self clock: sample just after the edge that raises it
            if (self)
            begin
                do
                begin
                    @(posedge core_clk);
                    #1;
                    n++;
                end
                while (!(sclk_oe && sclk_out) && n < 100);
                if (!(sclk_oe && sclk_out))
                    timed_out = 1'b1;
            end
            drv = !self;
            w = {w[18:0], sd};
            #80;
            drv = 1'b0;
            if (!self)
                #240;
        end
        #160;
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_sigma_delta_adc_serial_control.sv ----
`timescale 1ns/100ps
`default_nettype none
// bench for the serial output port
module test_sigma_delta_adc_serial_control;
    logic core_clk = 1'b0, rst_n = 1'b0, serial_mode_sel = 1'b0, range_select = 1'b0;
    logic sleep_n = 1'b1, cal_type_sel_a = 1'b0, cal_type_sel_b = 1'b0, cal_strobe = 1'b0;
    logic conv_valid = 1'b0;
    logic [19:0] conv_data = 20'h0;
    wire logic conv_ready, cs_n, sclk_in, sclk_out, sclk_oe, serial_out_line, serial_out_oe;
    wire logic word_valid_n, bipolar_reg, standby_reg, core_reset_reg, cal_start_reg;
    wire logic [1:0] cal_kind_reg;
    logic [19:0] words [4] = '{20'hA5C3E, 20'h80001, 20'h7FFFE, 20'h12345};
    int n_mismatch = 0, cmp_count = 0;
    adc_serial_port i_dut (.core_clk, .rst_n, .serial_mode_sel, .range_select, .sleep_n,
        .cal_type_sel_a, .cal_type_sel_b, .cal_strobe, .conv_valid, .conv_ready, .conv_data,
        .cs_n, .sclk_in, .sclk_out, .sclk_oe, .serial_out_line, .serial_out_oe, .word_valid_n,
        .bipolar_reg, .standby_reg, .core_reset_reg, .cal_start_reg, .cal_kind_reg);
    host_reader i_host (.core_clk, .cs_n, .sclk_in, .sclk_out, .sclk_oe, .serial_out_line,
        .serial_out_oe);
    // master clock
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a used-up wait counts as a mismatch and closes the run
    task automatic guard(input int n);
        if (n >= 400)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic wait_wv(input logic v);
        int n = 0;
        while (word_valid_n !== v && n < 400)
        begin
            tick();
            n++;
        end
        guard(n);
    endtask
    // hand one word to the buffer, held until taken
    task automatic push(input logic [19:0] w);
        int n = 0;
        conv_data = w;
        conv_valid = 1'b1;
        while (conv_ready !== 1'b1 && n < 400)
        begin
            tick();
            n++;
        end
        guard(n);
        tick();
        conv_valid = 1'b0;
        tick();
    endtask
    // main sequence
    initial
    begin
        logic [19:0] got;
        int n;
        tick(3);
        rst_n = 1'b1;
        chk("reset state", 20'h1C, {cal_kind_reg, word_valid_n, serial_out_oe, sclk_oe});
        tick(3);
        for (int m = 0; m < 2; m++)
        begin
            serial_mode_sel = m[0];
            tick(4);
            push(words[m]);
            chk("ready in hold", 20'h1, word_valid_n);
            wait_wv(1'b0);
            i_host.read_word(m[0], 20, got);
            guard(i_host.timed_out ? 400 : 0);
            chk("serial word", words[m], got);
            tick(8);
            chk("ready after send", 20'h1, word_valid_n);
            $display("mode %0d read done", m);
        end
        for (int i = 1; i < 4; i++)
            push(words[i]);
        tick(4);
        chk("buffer full", 20'h0, conv_ready);
        for (int i = 1; i < 4; i++)
        begin
            wait_wv(1'b0);
            i_host.read_word(1'b1, i == 3 ? 5 : 20, got);
            guard(i_host.timed_out ? 400 : 0);
            chk("buffered word", i == 3 ? words[3] >> 15 : words[i], got);
        end
        tick(12);
        chk("early deselect", 20'h0, {serial_out_oe, sclk_oe});
        $display("buffer read done");
        range_select = 1'b1;
        sleep_n = 1'b0;
        tick(5);
        chk("range and sleep", 20'h3, {bipolar_reg, standby_reg});
        range_select = 1'b0;
        sleep_n = 1'b1;
        cal_type_sel_a = 1'b1;
        tick(5);
        chk("range and sleep off", 20'h0, {bipolar_reg, standby_reg});
        cal_strobe = 1'b1;
        tick(9);
        chk("calibration reset", 20'h5, {core_reset_reg, cal_kind_reg});
        cal_strobe = 1'b0;
        n = 0;
        while (cal_start_reg !== 1'b1 && n < 6)
        begin
            tick();
            n++;
        end
        chk("calibration start", 20'h1, cal_start_reg);
        $display("config and calibration done");
        end_sim();
    end
endmodule
`default_nettype wire
